// ==== core/acsc_clk_mux.sv ====
// glitch-free clock source selector, sampled in the system clock domain
`timescale 1ns/100ps
module acsc_clk_mux
  import acsc_pkg::*;
#(
  parameter int SW = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [SW-1:0] sel,
  input wire logic [(1<<SW)-1:0] src,
  output logic clk_out
);
  acsc_mux_st_t state_r;
  logic [SW-1:0] cur_r;
  logic [3:0] hold_r;
  logic out_r;
  logic cur_src;

  assign cur_src = src[cur_r];
  assign clk_out = out_r;

  // leave the old source only on its low phase, then idle low before taking the new one;
  // a source stopped high stalls the change until it falls
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= MUX_RUN;
      cur_r <= '0;
      hold_r <= 4'h0;
      out_r <= 1'b0;
    end else begin
      case (state_r)
        MUX_RUN: begin
          if (sel != cur_r && !cur_src) begin
            out_r <= 1'b0;
            hold_r <= 4'(SWITCH_HOLD_CYC - 1);
            state_r <= MUX_HOLD;
          end else begin
            out_r <= cur_src;
          end
        end
        MUX_HOLD: begin
          out_r <= 1'b0;
          if (hold_r != 4'h0) begin
            hold_r <= hold_r - 4'h1;
          end else if (!src[sel]) begin
            cur_r <= sel;
            state_r <= MUX_RUN;
          end
        end
        default: state_r <= MUX_RUN;
      endcase
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  hold_low_a: assert property (state_r == MUX_HOLD |-> !out_r)
    else $error("clock selector output high during changeover");
  rise_src_a: assert property ($rose(out_r) |-> $past(cur_src) && $past(state_r) == MUX_RUN)
    else $error("clock selector output rose without its source");
endmodule : acsc_clk_mux

// ==== core/acsc_pkg.sv ====
// shared constants and types of the audio clock select block
package acsc_pkg;
  localparam int CLK_FREQ_MHZ = 250;
  localparam int SWITCH_HOLD_NS = 8;
  localparam int SWITCH_HOLD_CYC = (SWITCH_HOLD_NS * CLK_FREQ_MHZ + 999) / 1000;

  localparam logic [6:0] PLL_RATE_CONFIG_ADDR = 7'h75;
  localparam logic [6:0] CONVERTER_CLOCK_SELECT_ADDR = 7'h76;
  localparam logic [6:0] INTERNAL_CLOCK_SELECT_ADDR = 7'h77;
  localparam logic [6:0] PLL_REFERENCE_SELECT_ADDR = 7'h78;
  localparam logic [6:0] CLOCK_OUTPUT_ENABLE_ADDR = 7'h7A;

  localparam logic [7:0] PLL_RATE_CONFIG_RST = 8'h00;
  localparam logic [7:0] CONVERTER_CLOCK_SELECT_RST = 8'h00;
  localparam logic [7:0] INTERNAL_CLOCK_SELECT_RST = 8'h00;
  localparam logic [7:0] PLL_REFERENCE_SELECT_RST = 8'h00;
  localparam logic [7:0] CLOCK_OUTPUT_ENABLE_RST = 8'h00;

  localparam logic [7:0] INTERNAL_CLOCK_SELECT_MASK = 8'h1F;
  localparam logic [7:0] PLL_REFERENCE_SELECT_MASK = 8'hC0;
  localparam logic [7:0] CLOCK_OUTPUT_ENABLE_MASK = 8'h37;

  localparam int SEC_RATE_LSB = 6;
  localparam int SEC_RATIO_BIT = 5;
  localparam int SEC_DOUBLE_BIT = 4;
  localparam int FIRST_RATE_LSB = 2;
  localparam int FIRST_RATIO_BIT = 1;
  localparam int FIRST_DOUBLE_BIT = 0;
  localparam int DAC_SRC_LSB = 5;
  localparam int ADC_SRC_LSB = 2;
  localparam int ICLK_B_LSB = 0;
  localparam int ICLK_A_LSB = 3;
  localparam int SEC_INT_LSB = 1;
  localparam int FIRST_INT_BIT = 0;
  localparam int SEC_REF_BIT = 7;
  localparam int FIRST_REF_BIT = 6;
  localparam int RX_PD_BIT = 5;
  localparam int RX_MODE_BIT = 4;
  localparam int SYS_A_BIT = 2;
  localparam int SYS_B_BIT = 1;
  localparam int SYS_C_BIT = 0;

  localparam logic [1:0] RATE_48K = 2'h0;
  localparam logic [1:0] RATE_RSVD = 2'h1;
  localparam logic [1:0] RATE_32K = 2'h2;
  localparam logic [1:0] RATE_44K1 = 2'h3;
  localparam logic [25:0] BASE_48K_HZ = 26'h000BB80;
  localparam logic [25:0] BASE_32K_HZ = 26'h0007D00;
  localparam logic [25:0] BASE_44K1_HZ = 26'h000AC44;
  localparam logic [25:0] RATIO_LOW = 26'h0000100;
  localparam logic [25:0] RATIO_HIGH = 26'h0000180;

  localparam logic [1:0] ROUTE_PLL = 2'h0;
  localparam logic [1:0] ROUTE_RECOVERED = 2'h3;

  typedef enum logic {MUX_RUN, MUX_HOLD} acsc_mux_st_t;
endpackage : acsc_pkg

// ==== core/acsc_top.sv ====
// audio clock select and configuration registers
`timescale 1ns/100ps
module acsc_top
  import acsc_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [6:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  input wire logic XTAL_IN,
  input wire logic MCLK_IN,
  input wire logic FIRST_RATE_OUT,
  input wire logic SECOND_RATE_OUT,
  input wire logic THIRD_RATE_OUT,
  input wire logic RX_PLL_512,
  input wire logic RX_PLL_256,
  input wire logic RX_RECOVERED_CLK,
  input wire logic PLL_SYS_CLK_A,
  input wire logic PLL_SYS_CLK_B,
  input wire logic PLL_SYS_CLK_C,
  input wire logic [1:0] RECOVERED_CLOCK_ROUTE,
  input wire logic CRYSTAL_HALVE_ENABLE,
  output logic [1:0] FIRST_PLL_RATE_SEL,
  output logic FIRST_PLL_RATIO_SEL,
  output logic FIRST_PLL_RATE_DOUBLE,
  output logic [1:0] SECOND_PLL_RATE_SEL,
  output logic SECOND_PLL_RATIO_SEL,
  output logic SECOND_PLL_RATE_DOUBLE,
  output logic [25:0] FIRST_PLL_FREQ_HZ,
  output logic [25:0] SECOND_PLL_FREQ_HZ,
  output logic FIRST_PLL_REF_CLK,
  output logic SECOND_PLL_REF_CLK,
  output logic FIRST_PLL_INTERNAL_CLOCK,
  output logic SECOND_PLL_INTERNAL_CLOCK,
  output logic DAC_CLK,
  output logic ADC_CLK,
  output logic INTERNAL_CLOCK_A,
  output logic INTERNAL_CLOCK_B,
  output logic RECEIVER_POWER_DOWN,
  output logic RECEIVER_INPUT_MODE,
  output logic SYSTEM_CLOCK_OUT_A,
  output logic SYSTEM_CLOCK_OUT_B,
  output logic SYSTEM_CLOCK_OUT_C
);
  logic [7:0] rate_r;
  logic [7:0] conv_r;
  logic [7:0] int_r;
  logic [7:0] ref_r;
  logic [7:0] oen_r;
  logic [7:0] rdata_r;
  logic [25:0] first_freq_r;
  logic [25:0] sec_freq_r;
  logic route_r;
  logic [3:0] halve_src;
  logic [3:0] prev_r;
  logic [3:0] half_r;
  logic xtal_ref;
  logic first_int_clk;
  logic sec_int_clk;
  logic sysc_src;
  logic [2:0] sys_src;
  logic [2:0] gate_en_r;
  logic [2:0] sys_out_r;
  logic [1:0] sec_rate_nxt;
  logic [1:0] first_rate_nxt;

  // ---------------- register port ----------------

  // a reserved rate code is dropped and the field keeps its old value
  always_comb begin
    sec_rate_nxt = rate_r[SEC_RATE_LSB +: 2];
    first_rate_nxt = rate_r[FIRST_RATE_LSB +: 2];
    if (REG_WDATA[SEC_RATE_LSB +: 2] != RATE_RSVD) begin
      sec_rate_nxt = REG_WDATA[SEC_RATE_LSB +: 2];
    end
    if (REG_WDATA[FIRST_RATE_LSB +: 2] != RATE_RSVD) begin
      first_rate_nxt = REG_WDATA[FIRST_RATE_LSB +: 2];
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rate_r <= PLL_RATE_CONFIG_RST;
      conv_r <= CONVERTER_CLOCK_SELECT_RST;
      int_r <= INTERNAL_CLOCK_SELECT_RST;
      ref_r <= PLL_REFERENCE_SELECT_RST;
      oen_r <= CLOCK_OUTPUT_ENABLE_RST;
    end else if (REG_WR) begin
      if (REG_ADDR == PLL_RATE_CONFIG_ADDR) begin
        rate_r[SEC_RATE_LSB +: 2] <= sec_rate_nxt;
        rate_r[SEC_RATIO_BIT] <= REG_WDATA[SEC_RATIO_BIT];
        rate_r[SEC_DOUBLE_BIT] <= REG_WDATA[SEC_DOUBLE_BIT];
        rate_r[FIRST_RATE_LSB +: 2] <= first_rate_nxt;
        rate_r[FIRST_RATIO_BIT] <= REG_WDATA[FIRST_RATIO_BIT];
        rate_r[FIRST_DOUBLE_BIT] <= REG_WDATA[FIRST_DOUBLE_BIT];
      end else if (REG_ADDR == CONVERTER_CLOCK_SELECT_ADDR) begin
        conv_r <= REG_WDATA;
      end else if (REG_ADDR == INTERNAL_CLOCK_SELECT_ADDR) begin
        int_r <= REG_WDATA & INTERNAL_CLOCK_SELECT_MASK;
      end else if (REG_ADDR == PLL_REFERENCE_SELECT_ADDR) begin
        ref_r <= REG_WDATA & PLL_REFERENCE_SELECT_MASK;
      end else if (REG_ADDR == CLOCK_OUTPUT_ENABLE_ADDR) begin
        oen_r <= REG_WDATA & CLOCK_OUTPUT_ENABLE_MASK;
      end
    end
  end

  // read data is registered and stands until the next read
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_r <= 8'h00;
    end else if (REG_RD) begin
      if (REG_ADDR == PLL_RATE_CONFIG_ADDR) begin
        rdata_r <= rate_r;
      end else if (REG_ADDR == CONVERTER_CLOCK_SELECT_ADDR) begin
        rdata_r <= conv_r;
      end else if (REG_ADDR == INTERNAL_CLOCK_SELECT_ADDR) begin
        rdata_r <= int_r;
      end else if (REG_ADDR == PLL_REFERENCE_SELECT_ADDR) begin
        rdata_r <= ref_r;
      end else if (REG_ADDR == CLOCK_OUTPUT_ENABLE_ADDR) begin
        rdata_r <= oen_r;
      end else begin
        rdata_r <= 8'h00;
      end
    end
  end

  assign REG_RDATA = rdata_r;
  assign SECOND_PLL_RATE_SEL = rate_r[SEC_RATE_LSB +: 2];
  assign SECOND_PLL_RATIO_SEL = rate_r[SEC_RATIO_BIT];
  assign SECOND_PLL_RATE_DOUBLE = rate_r[SEC_DOUBLE_BIT];
  assign FIRST_PLL_RATE_SEL = rate_r[FIRST_RATE_LSB +: 2];
  assign FIRST_PLL_RATIO_SEL = rate_r[FIRST_RATIO_BIT];
  assign FIRST_PLL_RATE_DOUBLE = rate_r[FIRST_DOUBLE_BIT];
  assign RECEIVER_POWER_DOWN = oen_r[RX_PD_BIT];
  assign RECEIVER_INPUT_MODE = oen_r[RX_MODE_BIT];

  // ---------------- pll target frequency ----------------

  function automatic logic [25:0] pll_freq(input logic [1:0] code, input logic ratio,
                                           input logic dbl);
    logic [25:0] base;
    logic [25:0] f;
    case (code)
      RATE_32K: base = BASE_32K_HZ;
      RATE_44K1: base = BASE_44K1_HZ;
      default: base = BASE_48K_HZ;
    endcase
    f = 26'(base * (ratio ? RATIO_HIGH : RATIO_LOW));
    if (dbl) begin
      f = {f[24:0], 1'b0};
    end
    return f;
  endfunction : pll_freq

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      first_freq_r <= 26'h0000000;
      sec_freq_r <= 26'h0000000;
    end else begin
      first_freq_r <= pll_freq(rate_r[FIRST_RATE_LSB +: 2], rate_r[FIRST_RATIO_BIT],
                               rate_r[FIRST_DOUBLE_BIT]);
      sec_freq_r <= pll_freq(rate_r[SEC_RATE_LSB +: 2], rate_r[SEC_RATIO_BIT],
                             rate_r[SEC_DOUBLE_BIT]);
    end
  end

  assign FIRST_PLL_FREQ_HZ = first_freq_r;
  assign SECOND_PLL_FREQ_HZ = sec_freq_r;

  // ---------------- halving dividers ----------------

  assign halve_src = {THIRD_RATE_OUT, SECOND_RATE_OUT, FIRST_RATE_OUT, XTAL_IN};

  // each half toggles on its source's rising edge, so it lags by one system clock
  genvar gh;
  generate
    for (gh = 0; gh < 4; gh++) begin : g_half
      always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
          prev_r[gh] <= 1'b0;
          half_r[gh] <= 1'b0;
        end else begin
          prev_r[gh] <= halve_src[gh];
          if (halve_src[gh] && !prev_r[gh]) begin
            half_r[gh] <= !half_r[gh];
          end
        end
      end
    end
  endgenerate

  assign xtal_ref = CRYSTAL_HALVE_ENABLE ? half_r[0] : XTAL_IN;

  // ---------------- source selectors ----------------

  acsc_clk_mux #(.SW(1)) u_first_int (
    .clk(CLK),
    .rst_n(RST_N),
    .sel(int_r[FIRST_INT_BIT]),
    .src({half_r[1], FIRST_RATE_OUT}),
    .clk_out(first_int_clk)
  );

  acsc_clk_mux #(.SW(2)) u_sec_int (
    .clk(CLK),
    .rst_n(RST_N),
    .sel(int_r[SEC_INT_LSB +: 2]),
    .src({half_r[3], THIRD_RATE_OUT, half_r[2], SECOND_RATE_OUT}),
    .clk_out(sec_int_clk)
  );

  acsc_clk_mux #(.SW(1)) u_first_ref (
    .clk(CLK),
    .rst_n(RST_N),
    .sel(ref_r[FIRST_REF_BIT]),
    .src({MCLK_IN, xtal_ref}),
    .clk_out(FIRST_PLL_REF_CLK)
  );

  acsc_clk_mux #(.SW(1)) u_sec_ref (
    .clk(CLK),
    .rst_n(RST_N),
    .sel(ref_r[SEC_REF_BIT]),
    .src({MCLK_IN, xtal_ref}),
    .clk_out(SECOND_PLL_REF_CLK)
  );

  acsc_clk_mux #(.SW(2)) u_iclk_a (
    .clk(CLK),
    .rst_n(RST_N),
    .sel(int_r[ICLK_A_LSB +: 2]),
    .src({sec_int_clk, first_int_clk, MCLK_IN, XTAL_IN}),
    .clk_out(INTERNAL_CLOCK_A)
  );

  acsc_clk_mux #(.SW(2)) u_iclk_b (
    .clk(CLK),
    .rst_n(RST_N),
    .sel(conv_r[ICLK_B_LSB +: 2]),
    .src({sec_int_clk, first_int_clk, MCLK_IN, XTAL_IN}),
    .clk_out(INTERNAL_CLOCK_B)
  );

  acsc_clk_mux #(.SW(3)) u_dac (
    .clk(CLK),
    .rst_n(RST_N),
    .sel(conv_r[DAC_SRC_LSB +: 3]),
    .src({XTAL_IN, XTAL_IN, RX_PLL_256, RX_PLL_512, sec_int_clk, first_int_clk, MCLK_IN,
          XTAL_IN}),
    .clk_out(DAC_CLK)
  );

  acsc_clk_mux #(.SW(3)) u_adc (
    .clk(CLK),
    .rst_n(RST_N),
    .sel(conv_r[ADC_SRC_LSB +: 3]),
    .src({XTAL_IN, XTAL_IN, RX_PLL_256, RX_PLL_512, sec_int_clk, first_int_clk, MCLK_IN,
          XTAL_IN}),
    .clk_out(ADC_CLK)
  );

  assign FIRST_PLL_INTERNAL_CLOCK = first_int_clk;
  assign SECOND_PLL_INTERNAL_CLOCK = sec_int_clk;

  // reserved route codes leave the previous routing in place
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      route_r <= 1'b0;
    end else if (RECOVERED_CLOCK_ROUTE == ROUTE_PLL) begin
      route_r <= 1'b0;
    end else if (RECOVERED_CLOCK_ROUTE == ROUTE_RECOVERED) begin
      route_r <= 1'b1;
    end
  end

  acsc_clk_mux #(.SW(1)) u_route_c (
    .clk(CLK),
    .rst_n(RST_N),
    .sel(route_r),
    .src({RX_RECOVERED_CLK, PLL_SYS_CLK_C}),
    .clk_out(sysc_src)
  );

  // ---------------- system clock output gates ----------------

  assign sys_src[SYS_A_BIT] = PLL_SYS_CLK_A;
  assign sys_src[SYS_B_BIT] = PLL_SYS_CLK_B;
  assign sys_src[SYS_C_BIT] = sysc_src;

  // the enable only moves while the source is low, so no output pulse is cut short
  genvar gs;
  generate
    for (gs = 0; gs < 3; gs++) begin : g_sys
      always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
          gate_en_r[gs] <= 1'b0;
          sys_out_r[gs] <= 1'b0;
        end else begin
          if (!sys_src[gs]) begin
            gate_en_r[gs] <= !oen_r[gs];
          end
          sys_out_r[gs] <= sys_src[gs] & gate_en_r[gs];
        end
      end
    end
  endgenerate

  assign SYSTEM_CLOCK_OUT_A = sys_out_r[SYS_A_BIT];
  assign SYSTEM_CLOCK_OUT_B = sys_out_r[SYS_B_BIT];
  assign SYSTEM_CLOCK_OUT_C = sys_out_r[SYS_C_BIT];

  // ---------------- checks ----------------

  logic [7:0] wdata_q_r;
  logic [1:0] sec_rate;
  logic x_half;
  logic x_prev;
  logic c_out;
  logic c_off;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      wdata_q_r <= 8'h00;
    end else begin
      wdata_q_r <= REG_WDATA;
    end
  end

  assign sec_rate = rate_r[SEC_RATE_LSB +: 2];
  assign x_half = half_r[0];
  assign x_prev = prev_r[0];
  assign c_out = sys_out_r[SYS_C_BIT];
  assign c_off = oen_r[SYS_C_BIT];

  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);

  sequence rate_wr;
    REG_WR && REG_ADDR == PLL_RATE_CONFIG_ADDR;
  endsequence

  sequence sec_cfg_wr;
    rate_wr and (REG_WDATA[7:4] == 4'h2);
  endsequence

  sequence first_cfg_wr;
    rate_wr and (REG_WDATA[3:0] == 4'h9);
  endsequence

  sec_rate_a: assert property (rate_wr and (REG_WDATA[7:6] != RATE_RSVD)
                               |=> sec_rate == wdata_q_r[7:6])
    else $error("second pll rate field not written");
  rate_hold_a: assert property (rate_wr and (REG_WDATA[7:6] == RATE_RSVD) |=> $stable(sec_rate))
    else $error("reserved rate code changed the second pll rate");
  sec_freq_a: assert property (sec_cfg_wr |=> ##1 sec_freq_r == 26'h1194000)
    else $error("second pll 48k 384x frequency wrong");
  first_freq_a: assert property (first_cfg_wr |=> ##1 first_freq_r == 26'h0FA0000)
    else $error("first pll 32k 256x doubled frequency wrong");
  rx_pd_a: assert property (REG_WR && REG_ADDR == CLOCK_OUTPUT_ENABLE_ADDR
                            |=> RECEIVER_POWER_DOWN == wdata_q_r[5])
    else $error("receiver power down does not follow its bit");
  rx_mode_a: assert property (REG_WR && REG_ADDR == CLOCK_OUTPUT_ENABLE_ADDR
                              |=> RECEIVER_INPUT_MODE == wdata_q_r[4])
    else $error("receiver input mode does not follow its bit");
  sys_off_a: assert property (c_off && $past(c_off) && !c_out |=> !c_out)
    else $error("disabled system clock output c went high");
  half_div_a: assert property ($changed(x_half) |-> $past(XTAL_IN) && !$past(x_prev))
    else $error("crystal half toggled without a crystal rising edge");
  rsvd_read_a: assert property (REG_RD && REG_ADDR == INTERNAL_CLOCK_SELECT_ADDR
                                |=> REG_RDATA[7:5] == 3'h0)
    else $error("reserved bits read nonzero");
endmodule : acsc_top

// ==== test/acsc_clk_src.sv ====
// behavioural model of the free-running clock sources that feed the selector block
`timescale 1ns/100ps
module acsc_clk_src (
  input wire logic CLK,
  output logic XTAL_IN,
  output logic MCLK_IN,
  output logic FIRST_RATE_OUT,
  output logic SECOND_RATE_OUT,
  output logic THIRD_RATE_OUT,
  output logic RX_PLL_512,
  output logic RX_PLL_256,
  output logic RX_RECOVERED_CLK,
  output logic PLL_SYS_CLK_A,
  output logic PLL_SYS_CLK_B,
  output logic PLL_SYS_CLK_C
);
  // half periods in system cycles; all differ so each source is told apart by its edge count
  int half [11] = '{2, 3, 4, 5, 7, 9, 11, 15, 6, 8, 10};
  int cnt [11] = '{default: 0};
  logic [10:0] q = 11'h000;

  always @(posedge CLK) begin
    for (int i = 0; i < 11; i++) begin
      cnt[i] <= (cnt[i] >= half[i] - 1) ? 0 : cnt[i] + 1;
      q[i] <= (cnt[i] >= half[i] - 1) ? ~q[i] : q[i];
    end
  end

  assign {PLL_SYS_CLK_C, PLL_SYS_CLK_B, PLL_SYS_CLK_A, RX_RECOVERED_CLK, RX_PLL_256, RX_PLL_512,
    THIRD_RATE_OUT, SECOND_RATE_OUT, FIRST_RATE_OUT, MCLK_IN, XTAL_IN} = q;
endmodule : acsc_clk_src

// ==== test/tb.sv ====
// self-checking bench of the audio clock select block
`timescale 1ns/100ps
module tb;
  import acsc_pkg::*;
  localparam int W = 560;
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  logic REG_WR = 1'b0;
  logic REG_RD = 1'b0;
  logic [6:0] REG_ADDR = 7'h00;
  logic [7:0] REG_WDATA = 8'h00;
  logic [1:0] RECOVERED_CLOCK_ROUTE = 2'h0;
  logic CRYSTAL_HALVE_ENABLE = 1'b0;
  logic [7:0] REG_RDATA;
  logic XTAL_IN, MCLK_IN, FIRST_RATE_OUT, SECOND_RATE_OUT, THIRD_RATE_OUT;
  logic RX_PLL_512, RX_PLL_256, RX_RECOVERED_CLK, PLL_SYS_CLK_A, PLL_SYS_CLK_B, PLL_SYS_CLK_C;
  logic [1:0] FIRST_PLL_RATE_SEL, SECOND_PLL_RATE_SEL;
  logic [25:0] FIRST_PLL_FREQ_HZ, SECOND_PLL_FREQ_HZ;
  logic FIRST_PLL_RATIO_SEL, FIRST_PLL_RATE_DOUBLE, SECOND_PLL_RATIO_SEL, SECOND_PLL_RATE_DOUBLE;
  logic FIRST_PLL_REF_CLK, SECOND_PLL_REF_CLK, FIRST_PLL_INTERNAL_CLOCK, SECOND_PLL_INTERNAL_CLOCK;
  logic DAC_CLK, ADC_CLK, INTERNAL_CLOCK_A, INTERNAL_CLOCK_B;
  logic RECEIVER_POWER_DOWN, RECEIVER_INPUT_MODE;
  logic SYSTEM_CLOCK_OUT_A, SYSTEM_CLOCK_OUT_B, SYSTEM_CLOCK_OUT_C;
  logic [10:0] ov;
  logic [7:0] ics = 8'h00;
  int n [11];
  int bad_count = 0;
  int n_checks = 0;

  assign ov = {SYSTEM_CLOCK_OUT_C, SYSTEM_CLOCK_OUT_B, SYSTEM_CLOCK_OUT_A,
    SECOND_PLL_INTERNAL_CLOCK, FIRST_PLL_INTERNAL_CLOCK, SECOND_PLL_REF_CLK, FIRST_PLL_REF_CLK,
    INTERNAL_CLOCK_B, INTERNAL_CLOCK_A, ADC_CLK, DAC_CLK};

  initial forever #2 CLK = ~CLK;

  acsc_top i_acsc_top (.*);
  acsc_clk_src i_acsc_clk_src (.*);

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge CLK);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge CLK);
    REG_WR <= 1'b0;
  endtask : wr

  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    @(posedge CLK);
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    @(posedge CLK);
    REG_RD <= 1'b0;
    #1;
    check(REG_RDATA, exp);
  endtask : rd

  function automatic int per(input int i);
    return 2 * i_acsc_clk_src.half[i];
  endfunction : per

  function automatic int q1();
    return ics[0] ? 2 * per(2) : per(2);
  endfunction : q1

  function automatic int q2();
    return (ics[2] ? per(4) : per(3)) * (ics[1] ? 2 : 1);
  endfunction : q2

  function automatic int p4(input logic [1:0] s);
    return (s == 2'h0) ? per(0) : (s == 2'h1) ? per(1) : (s == 2'h2) ? q1() : q2();
  endfunction : p4

  function automatic int p8(input logic [2:0] c);
    return (c >= 3'h6) ? per(0) : (c == 3'h4) ? per(5) : (c == 3'h5) ? per(6) : p4(c[1:0]);
  endfunction : p8

  function automatic logic [31:0] fq(input logic [1:0] fs, input logic sel, input logic db);
    logic [31:0] b;
    b = (fs == RATE_32K) ? BASE_32K_HZ : (fs == RATE_44K1) ? BASE_44K1_HZ : BASE_48K_HZ;
    return b * (sel ? RATIO_HIGH : RATIO_LOW) * (db ? 2 : 1);
  endfunction : fq

  // edge counts over a window; the settle time covers the longest glitch-free changeover
  task automatic measure();
    logic [10:0] prev;
    repeat (64) @(negedge CLK);
    n = '{default: 0};
    prev = ov;
    repeat (W) begin
      @(negedge CLK);
      for (int i = 0; i < 11; i++) begin
        if (ov[i] && !prev[i]) n[i]++;
      end
      prev = ov;
    end
  endtask : measure

  task automatic near(input int o, input int p);
    int e;
    e = (p == 0) ? 0 : W / p;
    check((n[o] - e <= 1 && e - n[o] <= 1) ? e : n[o], e);
  endtask : near

  task automatic rate_chk(input logic [7:0] v);
    repeat (2) @(posedge CLK);
    #1;
    check(SECOND_PLL_RATE_SEL, v[7:6]);
    check(SECOND_PLL_RATIO_SEL, v[5]);
    check(SECOND_PLL_RATE_DOUBLE, v[4]);
    check(SECOND_PLL_FREQ_HZ, fq(v[7:6], v[5], v[4]));
    check(FIRST_PLL_RATE_SEL, v[3:2]);
    check(FIRST_PLL_RATIO_SEL, v[1]);
    check(FIRST_PLL_RATE_DOUBLE, v[0]);
    check(FIRST_PLL_FREQ_HZ, fq(v[3:2], v[1], v[0]));
    rd(PLL_RATE_CONFIG_ADDR, v);
  endtask : rate_chk

  task automatic t_reset();
    rd(PLL_RATE_CONFIG_ADDR, PLL_RATE_CONFIG_RST);
    rd(CONVERTER_CLOCK_SELECT_ADDR, CONVERTER_CLOCK_SELECT_RST);
    rd(INTERNAL_CLOCK_SELECT_ADDR, INTERNAL_CLOCK_SELECT_RST);
    rd(PLL_REFERENCE_SELECT_ADDR, PLL_REFERENCE_SELECT_RST);
    rd(CLOCK_OUTPUT_ENABLE_ADDR, CLOCK_OUTPUT_ENABLE_RST);
    check(FIRST_PLL_FREQ_HZ, fq(RATE_48K, 1'b0, 1'b0));
    check(SECOND_PLL_FREQ_HZ, fq(RATE_48K, 1'b0, 1'b0));
  endtask : t_reset

  task automatic t_rates();
    logic [1:0] tab [3] = '{RATE_48K, RATE_32K, RATE_44K1};
    logic [7:0] v;
    for (int i = 0; i < 8; i++) begin
      v = {tab[i % 3], i[0], i[1], tab[(i + 1) % 3], i[1], i[2]};
      wr(PLL_RATE_CONFIG_ADDR, v);
      rate_chk(v);
    end
    // 48k 384x undoubled on the second pll, 32k 256x doubled on the first
    v = 8'h29;
    wr(PLL_RATE_CONFIG_ADDR, v);
    rate_chk(v);
    // a reserved rate code keeps the old rate but the other bits of the write still land
    wr(PLL_RATE_CONFIG_ADDR, {RATE_RSVD, 2'h3, RATE_RSVD, 2'h3});
    rate_chk({v[7:6], 2'h3, v[3:2], 2'h3});
  endtask : t_rates

  task automatic t_conv();
    for (int i = 0; i < 8; i++) begin
      wr(CONVERTER_CLOCK_SELECT_ADDR, {i[2:0], ~i[2:0], i[1:0]});
      measure();
      near(0, p8(i[2:0]));
      near(1, p8(~i[2:0]));
      near(3, p4(i[1:0]));
    end
  endtask : t_conv

  task automatic t_int();
    for (int i = 0; i < 8; i++) begin
      ics = {3'h0, i[2:1], i[1:0], i[0]};
      wr(INTERNAL_CLOCK_SELECT_ADDR, {3'h7, ics[4:0]});
      rd(INTERNAL_CLOCK_SELECT_ADDR, ics);
      measure();
      near(2, p4(ics[4:3]));
      near(6, q1());
      near(7, q2());
      near(3, p4(2'h3));
    end
  endtask : t_int

  task automatic t_ref();
    int xp;
    for (int i = 0; i < 5; i++) begin
      @(posedge CLK);
      CRYSTAL_HALVE_ENABLE <= i[2];
      xp = i[2] ? 2 * per(0) : per(0);
      wr(PLL_REFERENCE_SELECT_ADDR, {i[1], i[0], 6'h3F});
      rd(PLL_REFERENCE_SELECT_ADDR, {i[1], i[0], 6'h00});
      measure();
      near(5, i[1] ? per(1) : xp);
      near(4, i[0] ? per(1) : xp);
    end
    @(posedge CLK);
    CRYSTAL_HALVE_ENABLE <= 1'b0;
  endtask : t_ref

  task automatic t_oen();
    logic [1:0] rt [4] = '{2'h3, 2'h1, 2'h0, 2'h2};
    logic [7:0] v;
    for (int i = 0; i < 8; i++) begin
      v = {2'h3, i[0], i[1], 1'b1, i[2:0]};
      wr(CLOCK_OUTPUT_ENABLE_ADDR, v);
      rd(CLOCK_OUTPUT_ENABLE_ADDR, v & CLOCK_OUTPUT_ENABLE_MASK);
      check(RECEIVER_POWER_DOWN, i[0]);
      check(RECEIVER_INPUT_MODE, i[1]);
      measure();
      near(8, i[2] ? 0 : per(8));
      near(9, i[1] ? 0 : per(9));
      near(10, i[0] ? 0 : per(10));
    end
    wr(CLOCK_OUTPUT_ENABLE_ADDR, 8'h00);
    // the two middle route codes keep whatever routing came before
    for (int k = 0; k < 4; k++) begin
      @(posedge CLK);
      RECOVERED_CLOCK_ROUTE <= rt[k];
      measure();
      near(10, (k < 2) ? per(7) : per(10));
    end
  endtask : t_oen

  task automatic t_map();
    wr(7'h79, 8'hFF);
    rd(7'h79, 8'h00);
    rd(7'h74, 8'h00);
    rd(CLOCK_OUTPUT_ENABLE_ADDR, 8'h00);
  endtask : t_map

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict

  initial begin
    repeat (2) @(posedge CLK);
    RST_N <= 1'b1;
    t_reset();
    t_rates();
    t_conv();
    t_int();
    t_ref();
    t_oen();
    t_map();
    give_verdict();
  end

  initial begin
    repeat (60000) @(posedge CLK);
    bad_count++;
    give_verdict();
  end
endmodule : tb
